// *** shared/irp_pkg.sv ***
// irp_pkg: frame layouts, opcodes, status codes for the interrupt-return /
// position-event command slice. assumes nine-byte command and reply frames.
package irp_pkg;
  localparam logic [7:0] OP_VECTOR = 8'h25;
  localparam logic [7:0] OP_RETURN = 8'h26;
  localparam logic [7:0] OP_UF_BASE = 8'h40;
  localparam int UF_COUNT = 8;
  localparam logic [7:0] OP_MOVE = 8'h04;
  localparam logic [7:0] OP_POS_REQ = 8'h8A;
  localparam logic [7:0] ST_OK = 8'h64;
  localparam logic [7:0] ST_POS_DONE = 8'h80;
  localparam logic [7:0] ST_BAD_CMD = 8'h02;
  localparam logic [7:0] ST_BAD_MODE = 8'h05;
  localparam logic [7:0] ST_BAD_SUM = 8'h01;
  localparam logic [7:0] TIMER0_IRQ = 8'h00;
  localparam logic [7:0] TYPE_ONCE = 8'h00;
  localparam logic [7:0] TYPE_EVERY = 8'h01;
  localparam logic [7:0] HOST_ADDR = 8'h02;
  localparam logic [7:0] MODULE_ADDR = 8'h01;
  localparam int FRAME_LEN = 9;

  typedef struct packed {
    logic [7:0] target;
    logic [7:0] opcode;
    logic [7:0] typ;
    logic [7:0] bank;
    logic [31:0] value;
    logic [7:0] sum;
  } irp_cmd_t;

  typedef struct packed {
    logic [7:0] reply;
    logic [7:0] origin;
    logic [7:0] status;
    logic [7:0] command;
    logic [31:0] value;
    logic [7:0] sum;
  } irp_reply_t;

  typedef struct packed {
    logic [31:0] accu;
    logic [31:0] xreg;
    logic [7:0] flags;
    logic [15:0] pc;
  } irp_ctx_t;

  function automatic logic [7:0] irp_sum8(input logic [63:0] bytes);
    logic [7:0] s;
    s = 8'h00;
    for (int i = 0; i < 8; i++)
    begin
      s = s + bytes[i*8 +: 8];
    end
    return s;
  endfunction
endpackage

// *** hw/irp_ctx_store.sv ***
// irp_ctx_store: one-deep save area for program context across a handler.
// assumes the sequencer never nests handlers.
`timescale 1ns/1ps
module irp_ctx_store (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // control
  input wire logic save,
  input wire logic restore,
  input wire irp_pkg::irp_ctx_t live,
  // saved context
  output irp_pkg::irp_ctx_t saved,
  output logic inHandler
);
  import irp_pkg::*;
  irp_ctx_t saved_r;
  logic inHandler_r;

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      saved_r <= '0;
    else if (save)
      saved_r <= live;
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      inHandler_r <= 1'b0;
    else if (save)
      inHandler_r <= 1'b1;
    else if (restore)
      inHandler_r <= 1'b0;
  end

  assign saved = saved_r;
  assign inHandler = inHandler_r;

  a_save_holds: assert property (@(posedge clk) disable iff (!reset_n)
    save |=> (saved_r == $past(live)) && inHandler_r)
    else $error("context not captured on save");
endmodule

// *** hw/irp_cmd_unit.sv ***
// irp_cmd_unit: decodes command frames for vector define, interrupt return,
// user functions and the position-reached request; builds reply frames.
// assumes a whole frame arrives in one cycle and reply taken on ready.
`timescale 1ns/1ps
module irp_cmd_unit #(
  parameter int PC_W = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // command frame in
  input wire logic cmdValid,
  output logic cmdReady,
  input wire irp_pkg::irp_cmd_t cmdFrame,
  input wire logic fromProgram,
  // reply frame out
  output logic replyValid,
  input wire logic replyReady,
  output irp_pkg::irp_reply_t replyFrame,
  // program context and interrupt entry
  input wire irp_pkg::irp_ctx_t liveCtx,
  input wire logic irqEnter,
  output logic restoreValid,
  output irp_pkg::irp_ctx_t restoreCtx,
  output logic [PC_W-1:0] timerVector,
  output logic timerVectorSet,
  // motion
  input wire logic moveIssued,
  input wire logic targetReached,
  // user function hook
  input wire logic [31:0] userValue
);
  import irp_pkg::*;

  irp_reply_t reply_r;
  logic replyValid_r;
  logic pendDone_r;
  logic armOnce_r;
  logic armEvery_r;
  logic moveWatch_r;
  logic [7:0] mask_r;
  logic restoreValid_r;
  irp_ctx_t restoreCtx_r;
  logic [PC_W-1:0] timerVector_r;
  logic timerVectorSet_r;
  irp_ctx_t savedCtx;
  logic inHandler;
  logic sumOk;
  logic isUser;
  logic take;
  logic doneFire;
  logic isReturn;

  function automatic irp_reply_t mk_reply(input logic [7:0] st, input logic [7:0] op,
                                          input logic [31:0] val);
    irp_reply_t r;
    r.reply = HOST_ADDR;
    r.origin = MODULE_ADDR;
    r.status = st;
    r.command = op;
    r.value = val;
    r.sum = irp_sum8({r.reply, r.origin, r.status, r.command, r.value});
    return r;
  endfunction

  // frame layout fixed by the struct order
  assign sumOk = cmdFrame.sum == irp_sum8(cmdFrame[71:8]);
  assign isUser = cmdFrame.opcode >= OP_UF_BASE
                  && cmdFrame.opcode < OP_UF_BASE + 8'(UF_COUNT);
  // completion reply has priority over a new command for the reply slot
  assign doneFire = pendDone_r && !replyValid_r;
  assign cmdReady = !replyValid_r && !pendDone_r;
  assign take = cmdValid && cmdReady;
  assign isReturn = take && sumOk && fromProgram && cmdFrame.opcode == OP_RETURN;

  irp_ctx_store u_ctx (
    .clk(clk),
    .reset_n(reset_n),
    .save(irqEnter && !inHandler),
    .restore(isReturn && inHandler),
    .live(liveCtx),
    .saved(savedCtx),
    .inHandler(inHandler)
  );

  // reply slot: immediate replies and completion replies
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      replyValid_r <= 1'b0;
      reply_r <= '0;
    end
    else if (replyValid_r)
    begin
      if (replyReady)
        replyValid_r <= 1'b0;
    end
    else if (doneFire)
    begin
      replyValid_r <= 1'b1;
      reply_r <= mk_reply(ST_POS_DONE, OP_POS_REQ, {24'h000000, mask_r});
    end
    else if (take && !fromProgram)
    begin
      replyValid_r <= 1'b1;
      if (!sumOk)
        reply_r <= mk_reply(ST_BAD_SUM, cmdFrame.opcode, 32'h00000000);
      else if (cmdFrame.opcode == OP_POS_REQ)
        reply_r <= mk_reply(ST_OK, OP_POS_REQ, {24'h000000, cmdFrame.value[7:0]});
      else if (isUser)
        reply_r <= mk_reply(ST_OK, cmdFrame.opcode, userValue);
      else if (cmdFrame.opcode == OP_RETURN || cmdFrame.opcode == OP_VECTOR)
        reply_r <= mk_reply(ST_BAD_MODE, cmdFrame.opcode, 32'h00000000);
      else
        reply_r <= mk_reply(ST_BAD_CMD, cmdFrame.opcode, 32'h00000000);
    end
  end

  // position-reached arming; a request from a program is ignored
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      armOnce_r <= 1'b0;
      armEvery_r <= 1'b0;
      mask_r <= 8'h00;
    end
    else if (take && sumOk && !fromProgram && cmdFrame.opcode == OP_POS_REQ)
    begin
      mask_r <= cmdFrame.value[7:0];
      armOnce_r <= cmdFrame.typ == TYPE_ONCE;
      armEvery_r <= cmdFrame.typ == TYPE_EVERY;
    end
    else if (moveIssued && armOnce_r)
      armOnce_r <= 1'b0;
  end

  // move being watched; completion pends until the reply slot is free
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      moveWatch_r <= 1'b0;
      pendDone_r <= 1'b0;
    end
    else
    begin
      if (moveIssued)
        moveWatch_r <= armOnce_r || armEvery_r;
      else if (targetReached && moveWatch_r)
        moveWatch_r <= 1'b0;
      if (targetReached && moveWatch_r && !moveIssued)
        pendDone_r <= 1'b1;
      else if (doneFire)
        pendDone_r <= 1'b0;
    end
  end

  // interrupt return and vector definition from a stored program
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      restoreValid_r <= 1'b0;
      restoreCtx_r <= '0;
      timerVector_r <= '0;
      timerVectorSet_r <= 1'b0;
    end
    else
    begin
      restoreValid_r <= isReturn && inHandler;
      if (isReturn && inHandler)
        restoreCtx_r <= savedCtx;
      if (take && sumOk && fromProgram && cmdFrame.opcode == OP_VECTOR
          && cmdFrame.typ == TIMER0_IRQ)
      begin
        timerVector_r <= cmdFrame.value[PC_W-1:0];
        timerVectorSet_r <= 1'b1;
      end
    end
  end

  assign replyValid = replyValid_r;
  assign replyFrame = reply_r;
  assign restoreValid = restoreValid_r;
  assign restoreCtx = restoreCtx_r;
  assign timerVector = timerVector_r;
  assign timerVectorSet = timerVectorSet_r;

  a_return_restore: assert property (@(posedge clk) disable iff (!reset_n)
    (isReturn && inHandler) |=> restoreValid && restoreCtx == $past(savedCtx))
    else $error("return did not restore context");
  a_return_program: assert property (@(posedge clk) disable iff (!reset_n)
    (take && !fromProgram && cmdFrame.opcode == OP_RETURN) |=> !restoreValid)
    else $error("return executed from host");
  a_pos_ack: assert property (@(posedge clk) disable iff (!reset_n)
    (take && sumOk && !fromProgram && cmdFrame.opcode == OP_POS_REQ)
    |=> replyValid && replyFrame.status == ST_OK && replyFrame.command == OP_POS_REQ
    && replyFrame.value == {24'h000000, $past(cmdFrame.value[7:0])})
    else $error("bad immediate position reply");
  a_done_reply: assert property (@(posedge clk) disable iff (!reset_n)
    doneFire |=> replyValid && replyFrame.status == ST_POS_DONE
    && replyFrame.command == OP_POS_REQ && replyFrame.value == {24'h000000, $past(mask_r)})
    else $error("bad completion reply");
  a_user_ok: assert property (@(posedge clk) disable iff (!reset_n)
    (take && sumOk && !fromProgram && isUser)
    |=> replyFrame.status == ST_OK && replyFrame.value == $past(userValue))
    else $error("user function status wrong");
  a_once_clear: assert property (@(posedge clk) disable iff (!reset_n)
    (moveIssued && armOnce_r && !take) |=> !armOnce_r)
    else $error("single-shot arm not consumed");
  a_every_keep: assert property (@(posedge clk) disable iff (!reset_n)
    (armEvery_r && !take) |=> armEvery_r)
    else $error("every-move arm lost");
  a_vector_set: assert property (@(posedge clk) disable iff (!reset_n)
    (take && sumOk && fromProgram && cmdFrame.opcode == OP_VECTOR && cmdFrame.typ == TIMER0_IRQ)
    |=> timerVector == $past(cmdFrame.value[PC_W-1:0]))
    else $error("timer vector not stored");
  a_reply_sum: assert property (@(posedge clk) disable iff (!reset_n)
    replyValid |-> replyFrame.sum == irp_sum8(replyFrame[71:8]))
    else $error("reply checksum wrong");
endmodule

// *** verif/irp_host_model.sv ***
// irp_host_model: host side, sends command frames and collects replies.
// assumes one command unit on the far side; replies are always taken.
`timescale 1ns/1ps
module irp_host_model (
  // clock
  input wire logic clk,
  // command side
  output logic cmdValid,
  input wire logic cmdReady,
  output irp_pkg::irp_cmd_t cmdFrame,
  output logic fromProgram,
  // reply side
  input wire logic replyValid,
  output logic replyReady,
  input wire irp_pkg::irp_reply_t replyFrame
);
  import irp_pkg::*;
  irp_reply_t got[$];
  initial
  begin
    cmdValid = 1'b0;
    cmdFrame = '0;
    fromProgram = 1'b0;
    replyReady = 1'b1;
  end
  always @(posedge clk)
  begin
    if (replyValid && replyReady)
    begin
      got.push_back(replyFrame);
    end
  end
  function automatic logic [7:0] sum72(input logic [71:0] f);
    logic [7:0] s;
    s = 8'h00;
    for (int i = 1; i < 9; i++)
    begin
      s = s + f[i*8 +: 8];
    end
    return s;
  endfunction
  function automatic irp_cmd_t mk(input logic [7:0] op, input logic [7:0] ty,
                                  input logic [7:0] bk, input logic [31:0] v);
    irp_cmd_t f;
    f = '{MODULE_ADDR, op, ty, bk, v, 8'h00};
    f.sum = sum72(f);
    return f;
  endfunction
  task automatic send(input irp_cmd_t f, input logic prog, output bit ok);
    bit rdy;
    ok = 1'b0;
    @(posedge clk);
    cmdValid <= 1'b1;
    cmdFrame <= f;
    fromProgram <= prog;
    for (int n = 0; n < 30 && !ok; n++)
    begin
      #1;
      rdy = cmdReady;
      @(posedge clk);
      ok = rdy;
    end
    cmdValid <= 1'b0;
    // released lines must not keep showing the last frame
    cmdFrame <= ~f;
    fromProgram <= ~prog;
  endtask
endmodule

// *** verif/interrupt_return_and_position_event_test.sv ***
// interrupt_return_and_position_event_test: scenarios for the command unit.
// assumes the host model on the command side; bench drives context and motion.
`timescale 1ns/1ps
module interrupt_return_and_position_event_test;
  import irp_pkg::*;
  logic clk = 1'b0, reset_n = 1'b0, cmdValid, cmdReady, fromProgram, replyValid, replyReady;
  logic restoreValid, timerVectorSet, irqEnter = 1'b0, moveIssued = 1'b0;
  logic targetReached = 1'b0;
  logic [31:0] userValue = 32'h0;
  logic [15:0] timerVector;
  irp_cmd_t cmdFrame;
  irp_reply_t replyFrame;
  irp_ctx_t liveCtx = '0, restoreCtx;
  int miscompares = 0, comparisons = 0;
  bit ok;
  always #10 clk = ~clk;
  irp_host_model host (.clk(clk), .cmdValid(cmdValid), .cmdReady(cmdReady),
    .cmdFrame(cmdFrame), .fromProgram(fromProgram), .replyValid(replyValid),
    .replyReady(replyReady), .replyFrame(replyFrame));
  irp_cmd_unit #(.PC_W(16)) DUT (.clk(clk), .reset_n(reset_n), .cmdValid(cmdValid),
    .cmdReady(cmdReady), .cmdFrame(cmdFrame), .fromProgram(fromProgram),
    .replyValid(replyValid), .replyReady(replyReady), .replyFrame(replyFrame),
    .liveCtx(liveCtx), .irqEnter(irqEnter), .restoreValid(restoreValid),
    .restoreCtx(restoreCtx), .timerVector(timerVector), .timerVectorSet(timerVectorSet),
    .moveIssued(moveIssued), .targetReached(targetReached), .userValue(userValue));
  task automatic tally_and_finish();
    if (miscompares == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input bit good, input string m);
    comparisons++;
    if (!good)
    begin
      $display("BAD %0t %s", $time, m);
      miscompares++;
    end
  endtask
  task automatic tx(input irp_cmd_t f, input logic prog);
    host.send(f, prog, ok);
    chk(ok, "frame not taken");
    if (!ok)
      tally_and_finish();
  endtask
  task automatic expect_reply(input logic [7:0] st, input logic [7:0] cm,
                              input logic [31:0] v, input bit useV);
    irp_reply_t r;
    for (int n = 0; n < 30 && host.got.size() == 0; n++)
      @(posedge clk);
    chk(host.got.size() != 0, "no reply");
    if (host.got.size() == 0)
      tally_and_finish();
    else
    begin
      r = host.got.pop_front();
      chk(r.reply === HOST_ADDR && r.origin === MODULE_ADDR && r.status === st
          && r.command === cm && r.sum === host.sum72(r) && (!useV || r.value === v),
          "reply frame");
    end
  endtask
  task automatic expect_none();
    repeat (8) @(posedge clk);
    chk(host.got.size() == 0, "unexpected reply");
    host.got.delete();
  endtask
  task automatic move();
    @(posedge clk) moveIssued <= 1'b1;
    @(posedge clk) moveIssued <= 1'b0;
    repeat (3) @(posedge clk);
    targetReached <= 1'b1;
    @(posedge clk) targetReached <= 1'b0;
  endtask
  task automatic t_pos_once();
    tx(host.mk(OP_POS_REQ, TYPE_ONCE, 8'h00, 32'h1), 1'b0);
    expect_reply(ST_OK, OP_POS_REQ, 32'h1, 1'b1);
    move();
    expect_reply(ST_POS_DONE, OP_POS_REQ, 32'h1, 1'b1);
    move();
    expect_none();
  endtask
  task automatic t_pos_refused();
    irp_cmd_t f;
    tx(host.mk(OP_POS_REQ, TYPE_EVERY, 8'h00, 32'h1), 1'b1);
    expect_none();
    f = host.mk(OP_POS_REQ, TYPE_EVERY, 8'h00, 32'h1);
    f.sum = f.sum ^ 8'h01;
    tx(f, 1'b0);
    expect_reply(ST_BAD_SUM, OP_POS_REQ, 32'h0, 1'b0);
    move();
    expect_none();
    tx(host.mk(OP_MOVE, 8'h00, 8'h00, 32'h0), 1'b0);
    expect_reply(ST_BAD_CMD, OP_MOVE, 32'h0, 1'b0);
  endtask
  task automatic t_pos_every();
    tx(host.mk(OP_POS_REQ, TYPE_EVERY, 8'h00, 32'h1), 1'b0);
    expect_reply(ST_OK, OP_POS_REQ, 32'h1, 1'b1);
    repeat (3)
    begin
      move();
      expect_reply(ST_POS_DONE, OP_POS_REQ, 32'h1, 1'b1);
    end
  endtask
  task automatic t_user();
    for (int i = 0; i < UF_COUNT; i++)
    begin
      @(posedge clk) userValue <= 32'hC0DE0000 + 32'(i);
      tx(host.mk(OP_UF_BASE + 8'(i), 8'(i), 8'h00, 32'h0), 1'b0);
      expect_reply(ST_OK, OP_UF_BASE + 8'(i), 32'hC0DE0000 + 32'(i), 1'b1);
    end
  endtask
  task automatic t_vector_return();
    irp_ctx_t ctxA;
    ctxA = '{32'h11112222, 32'h33334444, 8'h5A, 16'h0123};
    tx(host.mk(OP_VECTOR, TIMER0_IRQ, 8'h00, 32'h32), 1'b1);
    repeat (2) @(posedge clk);
    chk(timerVector === 16'h0032 && timerVectorSet === 1'b1, "vector");
    tx(host.mk(OP_VECTOR, 8'h01, 8'h00, 32'h77), 1'b1);
    repeat (2) @(posedge clk);
    chk(timerVector === 16'h0032, "vector of other source");
    @(posedge clk) liveCtx <= ctxA;
    irqEnter <= 1'b1;
    @(posedge clk) irqEnter <= 1'b0;
    liveCtx <= '{32'hFFFF0000, 32'h0000FFFF, 8'hA5, 16'h0456};
    // handler body ends with the return, don't-care fields scrambled
    tx(host.mk(OP_RETURN, 8'hFF, 8'h7E, 32'hDEADBEEF), 1'b1);
    // restore pulse stands only in the cycle after the frame is taken
    #1;
    chk(restoreValid === 1'b1 && restoreCtx === ctxA, "restore");
    tx(host.mk(OP_RETURN, 8'h00, 8'h00, 32'h0), 1'b1);
    #1;
    chk(restoreValid === 1'b0, "return outside handler");
    tx(host.mk(OP_RETURN, 8'h00, 8'h00, 32'h0), 1'b0);
    expect_reply(ST_BAD_MODE, OP_RETURN, 32'h0, 1'b0);
  endtask
  initial
  begin
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    t_pos_once();
    t_pos_refused();
    t_user();
    t_vector_return();
    t_pos_every();
    tally_and_finish();
  end
endmodule
